//--- verilog/acch_cfg.svh
// Constants for the auxiliary configuration command handler.
// Assumes a 200 MHz pclk; included by bare name.
`ifndef ACCH_CFG_SVH
`define ACCH_CFG_SVH

// Register byte offsets
`define ACCH_OFF_CTRL        12'h000
`define ACCH_OFF_STATUS      12'h004
`define ACCH_OFF_FMASK       12'h008
`define ACCH_OFF_FADDR       12'h00c
`define ACCH_OFF_FDATA_LO    12'h010
`define ACCH_OFF_FDATA_HI    12'h014
`define ACCH_OFF_IRQ_STAT    12'h018
`define ACCH_OFF_IRQ_EN      12'h01c
`define ACCH_OFF_IRQ_CLR     12'h020
`define ACCH_OFF_CMD_DATA    12'h024
`define ACCH_OFF_MSG         12'h028
`define ACCH_OFF_MSG_POP     12'h02c

// Command characters and codes
`define ACCH_CH_HASH         8'h23
`define ACCH_CH_CR           8'h0d
`define ACCH_CMD_FILTER      12'h697
`define ACCH_CMD_SENSE_BASE  12'h820
`define ACCH_CMD_HB_OFF      12'h830
`define ACCH_CMD_HB_ON       12'h831

// Reset values
`define ACCH_RST_SENSE_SEL   2'b00
`define ACCH_RST_HB_EN       1'b0

// Heartbeat idle interval: 3 minutes longest, rounded down
`define ACCH_HB_SECONDS      180
`define ACCH_CLK_HZ          200000000
`define ACCH_HB_CYCLES       (64'd180 * 64'd200000000)

// Interrupt bit positions
`define ACCH_IRQ_SENSE       0
`define ACCH_IRQ_HB          1
`define ACCH_IRQ_DONE        2
`define ACCH_IRQ_ERR         3

`endif

//--- verilog/acch_pkg.sv
// Types shared by the command handler files.
// Assumes acch_cfg.svh supplies the numbers.
package acch_pkg;

    // Kinds of message queued for the host
    typedef enum logic [1:0] {
        ACCH_MSG_NONE,
        ACCH_MSG_DONE,
        ACCH_MSG_SENSE,
        ACCH_MSG_STATUS
    } acch_msg_kind_t;

    // One message handed to the host transmitter
    typedef struct packed {
        acch_msg_kind_t kind;
        logic [1:0]     sense;
        logic           err;
    } acch_msg_t;

    // Stored group match filter
    typedef struct packed {
        logic [7:0]  mask;
        logic [7:0]  start;
        logic [63:0] bytes;
    } acch_filter_t;

endpackage : acch_pkg

//--- verilog/acch_hex_nibble.sv
// Converts one ASCII hex character to a nibble.
// Assumes plain 8-bit characters; case of A-F is free.
`timescale 1ns/1ps
`default_nettype none
module acch_hex_nibble
    import acch_pkg::*;
(
    input  wire logic [7:0] ch,
    output logic      [3:0] nib,
    output logic            ok
);
    // Range checks on the character
    wire is_dig = (ch >= 8'h30) && (ch <= 8'h39);
    wire is_up  = (ch >= 8'h41) && (ch <= 8'h46);
    wire is_lo  = (ch >= 8'h61) && (ch <= 8'h66);
    wire [7:0] d_dig = ch - 8'h30;
    wire [7:0] d_alp = (ch & 8'hdf) - 8'h37;

    assign ok  = is_dig | is_up | is_lo;
    assign nib = is_dig ? d_dig[3:0] : (ok ? d_alp[3:0] : 4'h0);
endmodule : acch_hex_nibble
`default_nettype wire

//--- verilog/acch_sense_watch.sv
// Watches one sense line for changes of state.
// Assumes the line is synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module acch_sense_watch
    import acch_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic line_in,
    input  wire logic enable,
    output logic      changed
);
    logic prev_r;     // Last sampled level
    logic armed_r;    // First sample taken after reset

    // Sample each cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_r  <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            prev_r  <= line_in;
            armed_r <= 1'b1;
        end
    end

    // No report for the reset value, only real edges
    assign changed = enable & armed_r & (prev_r ^ line_in);
endmodule : acch_sense_watch
`default_nettype wire

//--- verilog/acch_cmd_handler.sv
// Auxiliary configuration command handler with APB registers.
// Assumes software feeds host command characters over APB
// and drains queued messages toward the serial link.
//
// Added by the designer: the APB register port and the register offsets.
`include "acch_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module acch_cmd_handler
    import acch_pkg::*;
#(
    parameter logic [63:0] HB_CYCLES = `ACCH_HB_CYCLES
)
(
    // Clock, reset and APB slave side
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Sense lines and report options
    input  wire logic        sense_line_a,
    input  wire logic        sense_line_b,
    input  wire logic        aux_append_en,
    output logic             msg_sent,
    // Stored filter for the tag protocol engine
    output logic      [7:0]  compare_byte_mask,
    output logic      [7:0]  compare_start_address,
    output logic      [63:0] compare_bytes,
    // Level interrupt toward the processor
    output logic             irq
);
    // Parser states
    typedef enum logic [1:0] { PS_IDLE, PS_BODY } acch_ps_t;

    acch_ps_t     ps_r;          // Parser state
    logic [4:0]   cnt_r;         // Characters taken after '#'
    logic [11:0]  code_r;        // First three digits
    logic [79:0]  arg_r;         // Filter argument nibbles
    logic         bad_r;         // Non-hex seen
    acch_filter_t filt_r;        // Stored filter
    logic [1:0]   sense_sel_r;   // Monitored lines
    logic         hb_en_r;       // Heartbeat enable
    logic [63:0]  idle_r;        // Silence counter
    acch_msg_t    msg_r;         // Pending message, one deep
    logic         msg_v_r;       // Pending message valid
    logic [3:0]   ist_r;         // Sticky interrupt status
    logic [3:0]   ien_r;         // Interrupt enables

    // APB decode
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire w_ctrl   = wr & (paddr == `ACCH_OFF_CTRL);
    wire w_iclr   = wr & (paddr == `ACCH_OFF_IRQ_CLR);
    wire w_ien    = wr & (paddr == `ACCH_OFF_IRQ_EN);
    wire w_char   = wr & (paddr == `ACCH_OFF_CMD_DATA);
    wire r_pop    = rd & (paddr == `ACCH_OFF_MSG_POP);
    wire mapped   = (paddr <= `ACCH_OFF_MSG_POP) && (paddr[1:0] == 2'b00);
    wire [7:0] ch = pwdata[7:0];

    // Hex conversion of the incoming character
    // Only the character on the bus now needs converting
    logic [3:0] nib;
    logic       nib_ok;
    acch_hex_nibble u_hex (
        .ch  (ch),
        .nib (nib),
        .ok  (nib_ok)
    );

    // Sense line change detectors
    logic chg_a;
    logic chg_b;
    acch_sense_watch u_wa (
        .pclk    (pclk),
        .presetn (presetn),
        .line_in (sense_line_a),
        .enable  (sense_sel_r[0]),
        .changed (chg_a)
    );
    acch_sense_watch u_wb (
        .pclk    (pclk),
        .presetn (presetn),
        .line_in (sense_line_b),
        .enable  (sense_sel_r[1]),
        .changed (chg_b)
    );

    // End of command line decode
    wire eol       = w_char & (ch == `ACCH_CH_CR) & (ps_r == PS_BODY);
    wire is_filt   = (code_r == `ACCH_CMD_FILTER) && (cnt_r == 5'd23);
    // Codes 820 to 823 share all but the two low bits
    wire [11:0] sense_base = `ACCH_CMD_SENSE_BASE;
    wire is_sense  = (code_r[11:2] == sense_base[11:2])
                     && (cnt_r == 5'd3);
    wire is_hboff  = (code_r == `ACCH_CMD_HB_OFF) && (cnt_r == 5'd3);
    wire is_hbon   = (code_r == `ACCH_CMD_HB_ON) && (cnt_r == 5'd3);
    wire cmd_ok    = eol & ~bad_r & (is_filt | is_sense | is_hboff | is_hbon);
    wire cmd_err   = eol & ~cmd_ok;

    // Events competing for the one-deep message slot
    wire ev_sense  = chg_a | chg_b;
    wire hb_due    = hb_en_r & (idle_r >= HB_CYCLES - 64'd1);
    wire slot_free = ~msg_v_r | r_pop;
    // Command answers first, then sense reports, then heartbeat
    wire put_done  = eol & slot_free;
    wire put_sense = ev_sense & slot_free & ~eol;
    // Only an empty slot takes a heartbeat, so a pop restarts the timer first
    wire put_hb    = hb_due & ~msg_v_r & ~eol & ~ev_sense;
    wire [1:0] sense_now = aux_append_en ? {sense_line_b, sense_line_a} : 2'b00;

    // Message presented to the serial side when popped
    assign msg_sent = r_pop & msg_v_r;

    // Parser: collect '#' then digits until carriage return
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps_r   <= PS_IDLE;
            cnt_r  <= 5'd0;
            code_r <= 12'h000;
            arg_r  <= 80'h0;
            bad_r  <= 1'b0;
        end
        else if (w_char)
        begin
            // A hash restarts the line, even part way through
            if (ch == `ACCH_CH_HASH)
            begin
                ps_r  <= PS_BODY;
                cnt_r <= 5'd0;
                bad_r <= 1'b0;
            end
            else if (ps_r == PS_BODY)
            begin
                // Carriage return closes the line; settings act on it
                if (ch == `ACCH_CH_CR)
                    ps_r <= PS_IDLE;
                else
                begin
                    // Overlong lines saturate and fail the length check
                    cnt_r <= (cnt_r == 5'd31) ? cnt_r : cnt_r + 5'd1;
                    bad_r <= bad_r | ~nib_ok;
                    if (cnt_r < 5'd3)
                        code_r <= {code_r[7:0], nib};
                    else
                        arg_r <= {arg_r[75:0], nib};
                end
            end
        end
    end

    // Settings store, applied on a good command or a direct control write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt_r      <= '0;
            sense_sel_r <= `ACCH_RST_SENSE_SEL;
            hb_en_r     <= `ACCH_RST_HB_EN;
        end
        else if (cmd_ok)
        begin
            if (is_filt)
                filt_r <= arg_r;       // Mask, start, then first byte at top
            if (is_sense)
                sense_sel_r <= code_r[1:0];
            if (is_hboff)
                hb_en_r <= 1'b0;
            if (is_hbon)
                hb_en_r <= 1'b1;
        end
        // A direct control write loses to a command ending at once
        else if (w_ctrl)
        begin
            sense_sel_r <= pwdata[1:0];
            hb_en_r     <= pwdata[2];
        end
    end

    // Idle timer restarts on every message handed out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_r <= 64'd0;
        else if (msg_sent || !hb_en_r)
            idle_r <= 64'd0;
        // Holds at the threshold until a message is popped
        else if (!hb_due)
            idle_r <= idle_r + 64'd1;
    end

    // One-deep outgoing message slot
    // A full slot drops the newcomer; software should pop promptly
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msg_r   <= '0;
            msg_v_r <= 1'b0;
        end
        else if (put_done)
        begin
            msg_r   <= '{kind: ACCH_MSG_DONE, sense: 2'b00, err: cmd_err};
            msg_v_r <= 1'b1;
        end
        else if (put_sense)
        begin
            // Queued the same way as a tag report
            msg_r   <= '{kind: ACCH_MSG_SENSE, sense: sense_now, err: 1'b0};
            msg_v_r <= 1'b1;
        end
        else if (put_hb)
        begin
            // Same layout as the RF status query answer
            msg_r   <= '{kind: ACCH_MSG_STATUS, sense: sense_now, err: 1'b0};
            msg_v_r <= 1'b1;
        end
        else if (r_pop)
            msg_v_r <= 1'b0;
    end

    // Sticky interrupt status; a set beats a clear in the same cycle
    wire [3:0] ev_vec = {cmd_err, cmd_ok, put_hb, put_sense};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_r <= 4'h0;
            ien_r <= 4'h0;
        end
        else
        begin
            ist_r <= (ist_r & ~(w_iclr ? pwdata[3:0] : 4'h0)) | ev_vec;
            if (w_ien)
                ien_r <= pwdata[3:0];
        end
    end
    // Level output while any enabled sticky bit is set
    assign irq = |(ist_r & ien_r);

    // Filter outputs for the tag protocol engine
    assign compare_byte_mask     = filt_r.mask;
    assign compare_start_address = filt_r.start;
    assign compare_bytes         = filt_r.bytes;

    // An empty slot reads as zero, so no stale message is shown
    wire [31:0] msg_word = msg_v_r ? {26'h0, 1'b1, msg_r} : 32'h0;

    // Read data mux
    logic [31:0] rmux;
    always_comb
    begin
        case (paddr)
            `ACCH_OFF_CTRL:     rmux = {29'h0, hb_en_r, sense_sel_r};
            `ACCH_OFF_STATUS:   rmux = {26'h0, ps_r == PS_BODY, msg_v_r, 2'b00,
                                        sense_line_b, sense_line_a};
            `ACCH_OFF_FMASK:    rmux = {24'h0, filt_r.mask};
            `ACCH_OFF_FADDR:    rmux = {24'h0, filt_r.start};
            `ACCH_OFF_FDATA_LO: rmux = filt_r.bytes[31:0];
            `ACCH_OFF_FDATA_HI: rmux = filt_r.bytes[63:32];
            `ACCH_OFF_IRQ_STAT: rmux = {28'h0, ist_r};
            `ACCH_OFF_IRQ_EN:   rmux = {28'h0, ien_r};
            `ACCH_OFF_MSG,
            `ACCH_OFF_MSG_POP:  rmux = msg_word;
            default:            rmux = 32'h0;
        endcase
    end

    // Read data held in a flop, taken at the setup edge
    // A pop read therefore shows the word as it stood before the pop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= rmux;
    end

    // Zero wait state slave; unmapped access flagged
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
endmodule : acch_cmd_handler
`default_nettype wire

//--- verif/acch_checker.sv
// Port-level property checker for the command handler.
// Assumes it is bound onto acch_cmd_handler; one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module acch_checker
    import acch_pkg::*;
#(
    parameter logic [63:0] HB_CYCLES = 64'd50
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        msg_sent,
    input wire logic [7:0]  compare_byte_mask,
    input wire logic [7:0]  compare_start_address,
    input wire logic [63:0] compare_bytes,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase of any transfer
    wire acc  = psel && penable;
    // Word-aligned and inside the map
    wire good = (paddr <= 12'h02c) && (paddr[1:0] == 2'b00);
    // Access phase of a pop read
    wire pop  = acc && !pwrite && (paddr == 12'h02c);

    property p_rdy;
        acc |-> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("access phase without ready");
    property p_err;
        acc && !good |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("bad address not refused");
    property p_ok;
        acc && good |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped address refused");
    property p_rd0;
        acc && !pwrite && pslverr |-> prdata == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("refused read not zero");
    // Filter moves only on an APB write access
    property p_filt;
        !(acc && pwrite) |=> $stable({compare_byte_mask, compare_start_address, compare_bytes});
    endproperty
    a_filt: assert property (p_filt) else $error("filter changed without a write");
    property p_pop;
        msg_sent |-> pop || $past(pop);
    endproperty
    a_pop: assert property (p_pop) else $error("message sent without pop");
    // Two cycles allow for a registered output
    property p_ien0;
        acc && pwrite && paddr == 12'h01c && pwdata[3:0] == 4'h0 |-> ##2 !irq;
    endproperty
    a_ien0: assert property (p_ien0) else $error("masked interrupt still high");
    property p_rst;
        $rose(presetn) |-> !irq ##1 !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("interrupt high after reset");
endmodule : acch_checker
bind acch_cmd_handler acch_checker #(.HB_CYCLES(HB_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_sent(msg_sent), .compare_byte_mask(compare_byte_mask),
    .compare_start_address(compare_start_address), .compare_bytes(compare_bytes), .irq(irq));
`default_nettype wire

//--- verif/acch_host_model.sv
// Host computer model: APB master that feeds command strings.
// Assumes the handler answers when pready is high at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module acch_host_model
(
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic      [11:0] paddr = 12'h0,
    output logic      [31:0] pwdata = 32'h0
);
    // One transfer; request held until ready is sampled
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Characters one per write, closed by carriage return
    task automatic send(input string s);
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < s.len(); i++)
            xfer(1'b1, 12'h024, {24'h0, s[i]}, q, e);
        xfer(1'b1, 12'h024, 32'h0000000d, q, e);
    endtask : send
endmodule : acch_host_model
`default_nettype wire

//--- verif/aux_config_command_handler_test.sv
// Self-checking bench for the command handler.
// Assumes the host model and checker are compiled alongside.
`include "acch_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module aux_config_command_handler_test;
    import acch_pkg::*;
    localparam logic [63:0] HB = 64'd50; // Short idle interval
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             sense_line_a = 1'b0;
    logic             sense_line_b = 1'b0;
    logic             aux_append_en = 1'b0;
    wire logic        psel, penable, pwrite, pready, pslverr, msg_sent, irq;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [7:0]  compare_byte_mask, compare_start_address;
    wire logic [63:0] compare_bytes;
    int               errors = 0, cmp_count = 0, cyc = 0, t0, sent_cnt = 0;
    logic [31:0]      q;
    logic             e;
    always #2.5 pclk = ~pclk;
    acch_cmd_handler #(.HB_CYCLES(HB)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sense_line_a(sense_line_a), .sense_line_b(sense_line_b),
        .aux_append_en(aux_append_en), .msg_sent(msg_sent), .compare_byte_mask(compare_byte_mask),
        .compare_start_address(compare_start_address), .compare_bytes(compare_bytes), .irq(irq));
    acch_host_model i_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // Hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            stop_test();
        end
    end
    // Messages handed to the serial side
    always @(posedge pclk)
        if (msg_sent === 1'b1)
            sent_cnt <= sent_cnt + 1;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        i_host.xfer(1'b0, a, 32'h0, q, e);
        check(64'(q), 64'(exp), what);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q, e);
        repeat (2) @(negedge pclk);
    endtask : wr
    // Expected slot word; sense field only with append on
    function automatic logic [31:0] msgv(input logic [1:0] kind, input logic err);
        return {26'h0, 1'b1, kind, aux_append_en ? {sense_line_b, sense_line_a} : 2'b00, err};
    endfunction : msgv
    // Command, then its answer read and popped
    task automatic cmd(input string s, input logic err);
        i_host.send(s);
        rd(`ACCH_OFF_MSG, {26'h0, 1'b1, 2'd1, 2'b00, err}, s);
        i_host.xfer(1'b0, `ACCH_OFF_MSG_POP, 32'h0, q, e);
    endtask : cmd
    task automatic toggle(input logic b);
        @(posedge pclk);
        if (b)
            sense_line_b <= ~sense_line_b;
        else
            sense_line_a <= ~sense_line_a;
        repeat (6) @(negedge pclk);
    endtask : toggle
    task automatic t_reset();
        rd(`ACCH_OFF_CTRL, 32'h0, "ctrl");
        check({compare_byte_mask, compare_start_address, 48'h0}, 64'h0, "fmask");
        check(compare_bytes, 64'h0, "fbytes");
        check(64'(irq), 64'h0, "irq");
        $display("test reset done");
    endtask : t_reset
    // Tag side: byte i meets memory at start+i, masked bytes only
    function automatic logic tag_hit(input logic [63:0] win);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < 8; i++)
            if (compare_byte_mask[7 - i] && compare_bytes[63 - 8 * i -: 8] != win[63 - 8 * i -: 8])
                hit = 1'b0;
        return hit;
    endfunction : tag_hit
    task automatic t_filter();
        cmd("#697A40A0005014202024133", 1'b0);
        check(64'(compare_byte_mask), 64'ha4, "mask");
        check(64'(compare_start_address), 64'h0a, "start");
        check(compare_bytes, 64'h0005014202024133, "bytes");
        rd(`ACCH_OFF_FDATA_HI, 32'h00050142, "fdata_hi");
        check(64'(tag_hit(64'h0005014202024133)), 64'h1, "tag_same");
        check(64'(tag_hit(64'h00ff01ffff02ffff)), 64'h1, "tag_unmasked");
        check(64'(tag_hit(64'h0105014202024133)), 64'h0, "tag_first");
        check(64'(tag_hit(64'h0005014202034133)), 64'h0, "tag_sixth");
        cmd("#697A4", 1'b1);
        check(compare_bytes, 64'h0005014202024133, "kept");
        aux_append_en <= 1'b1;
        $display("test filter done");
    endtask : t_filter
    task automatic t_sense();
        for (int n = 0; n < 4; n++)
        begin
            cmd($sformatf("#82%0d", n), 1'b0);
            rd(`ACCH_OFF_CTRL, 32'(n), "sel");
            for (int b = 0; b < 2; b++)
            begin
                toggle(b[0]);
                rd(`ACCH_OFF_MSG, n[b] ? msgv(2'd2, 1'b0) : 32'h0, "sense");
                i_host.xfer(1'b0, `ACCH_OFF_MSG_POP, 32'h0, q, e);
            end
        end
        $display("test sense done");
    endtask : t_sense
    task automatic t_irq();
        wr(`ACCH_OFF_IRQ_EN, 32'h1);
        rd(`ACCH_OFF_IRQ_STAT, 32'hd, "stat");
        check(64'(irq), 64'h1, "irq_on");
        wr(`ACCH_OFF_IRQ_CLR, 32'hf);
        check(64'(irq), 64'h0, "irq_clr");
        toggle(1'b0);
        check(64'(irq), 64'h1, "irq_sense");
        i_host.xfer(1'b0, `ACCH_OFF_MSG_POP, 32'h0, q, e);
        wr(`ACCH_OFF_IRQ_EN, 32'h0);
        check(64'(irq), 64'h0, "irq_mask");
        wr(`ACCH_OFF_IRQ_CLR, 32'hf);
        rd(`ACCH_OFF_IRQ_STAT, 32'h0, "stat_clr");
        i_host.xfer(1'b0, 12'h030, 32'h0, q, e);
        check({31'h0, e, q}, 64'h100000000, "unmapped");
        $display("test irq done");
    endtask : t_irq
    task automatic t_hb();
        cmd("#831", 1'b0);
        t0 = cyc;
        q = 32'h0;
        for (int k = 0; k < 40 && !q[5]; k++)
            i_host.xfer(1'b0, `ACCH_OFF_MSG, 32'h0, q, e);
        check(64'(q), 64'(msgv(2'd3, 1'b0)), "status");
        check(64'(cyc - t0 >= HB - 4 && cyc - t0 <= HB + 8), 64'h1, "interval");
        i_host.xfer(1'b0, `ACCH_OFF_MSG_POP, 32'h0, q, e);
        rd(`ACCH_OFF_CTRL, 32'h7, "hb_on");
        cmd("#830", 1'b0);
        repeat (150) @(posedge pclk);
        rd(`ACCH_OFF_MSG, 32'h0, "hb_off");
        rd(`ACCH_OFF_IRQ_STAT, 32'h6, "stat_hb");
        check(64'(sent_cnt), 64'd14, "sent");
        $display("test heartbeat done");
    endtask : t_hb
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_filter();
        t_sense();
        t_irq();
        t_hb();
        stop_test();
    end
endmodule : aux_config_command_handler_test
`default_nettype wire
